// ==== logic/pm_clock_pkg.sv ====
// ***********************************************************************
// Power-managed clock switch constants
// ***********************************************************************
package pm_clock_pkg;

   // ********************************************************************
   // Register byte offsets
   // ********************************************************************
   localparam logic [7:0] OSC_CTRL_OFFSET = 8'h00;
   localparam logic [7:0] SEC_TIMER_CTRL_OFFSET = 8'h04;
   localparam logic [7:0] MODE_STATUS_OFFSET = 8'h08;

   // ********************************************************************
   // Field positions
   // ********************************************************************
   localparam int SRC_SEL_LSB = 0;
   localparam int INT_STABLE_BIT = 2;
   localparam int PRIMARY_RUN_MODE_BIT = 3;
   localparam int IDLE_SEL_BIT = 4;
   localparam int SLEEP_SEL_BIT = 5;
   localparam int SECONDARY_RUN_MODE_BIT = 6;
   localparam int STATE_LSB = 0;
   localparam int ACTIVE_SRC_LSB = 4;
   localparam int PENDING_BIT = 8;

   // ********************************************************************
   // Clock source encoding; code 11 also means the internal block
   // ********************************************************************
   localparam logic [1:0] SRC_PRIMARY = 2'h0;
   localparam logic [1:0] SRC_SECONDARY = 2'h1;
   localparam logic [1:0] SRC_INTERNAL = 2'h2;
   localparam int NUM_SRC = 3;

   // ********************************************************************
   // Reset values and counts
   // ********************************************************************
   localparam logic [1:0] SRC_SEL_RESET = SRC_PRIMARY;
   localparam logic [7:0] SEC_TIMER_CTRL_RESET = 8'h00;
   localparam logic [3:0] SETTLE_EDGES = 4'h8;

   typedef enum logic [2:0] {
      ST_ACTIVE = 3'b000,
      ST_STOP = 3'b001,
      ST_SETTLE = 3'b010,
      ST_IDLE = 3'b011,
      ST_SLEEP = 3'b100
   } pm_state_e;

endpackage : pm_clock_pkg

// ==== logic/pm_clock_switch.sv ====
// Behaviour
// - Select field picks primary, secondary or internal
// - Select changes wait for the sleep trigger
// - Clocks stop the cycle after sleep
// - Eight new-source periods before clocks resume
// - At most one flag outside primary run
// - Primary flag set while primary drives clock
// - Internal flag set when stable internal drives
// - Secondary flag set while secondary drives clock
// - No flag means slow RC or unstable internal
// - Internal primary may show both flags
// - Internal mode entry clears primary flag
// - Sleep only triggers the selected mode
// - Idle and select sampled at each sleep
// - Run and idle choose source alike
// - Source change at sleep performs a switch, except in full sleep
// - Idle stops the processor, run clocks it
// - Watchdog wakes from idle, resets in run
// - Wake resumes run, then auto-switch to primary
// - Wake leaves idle and select bits alone
`timescale 1ns/1ps
module pm_clock_switch
   import pm_clock_pkg::*;
(
   // Clock and reset
   input wire logic CLK,
   input wire logic RST,
   // APB slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // Processor core events
   input wire logic SLEEP_EXEC,
   input wire logic WDT_TIMEOUT,
   input wire logic WAKE_EVENT,
   // Oscillators
   input wire logic PRI_OSC_CLK,
   input wire logic SEC_OSC_CLK,
   input wire logic INT_OSC_CLK,
   input wire logic PRI_READY,
   input wire logic INT_STABLE,
   input wire logic PRI_IS_INTERNAL,
   // Clock gating and reset request
   output logic SYS_CLK_EN,
   output logic CPU_CLK_EN,
   output logic [1:0] ACTIVE_SRC,
   output logic WDT_RESET
);

   // ********************************************************************
   // Declarations
   // ********************************************************************
   logic [2:0] pin_s1;
   logic [2:0] pin_s2;
   logic pri_ready_s;
   logic int_stable_s;
   logic pri_int_s;
   logic [1:0] src_sel;
   logic idle_sel;
   logic sleep_sel;
   logic [7:0] sec_ctrl;
   logic [1:0] next_src_sel;
   logic next_idle_sel;
   logic next_sleep_sel;
   logic [7:0] next_sec_ctrl;
   logic [31:0] next_prdata;
   logic wr_en;
   logic rd_setup;
   logic mapped;
   pm_state_e state;
   pm_state_e next_state;
   logic [1:0] active_src;
   logic [1:0] next_active_src;
   logic [1:0] tgt_src;
   logic [1:0] next_tgt_src;
   logic tgt_idle;
   logic next_tgt_idle;
   logic tgt_sleep;
   logic next_tgt_sleep;
   logic pending_pri;
   logic next_pending_pri;
   logic next_wdt_reset;
   logic settle_start;
   logic settle_done;
   logic [1:0] sel_src;
   logic auto_go;
   logic complete;
   logic pri_flag;
   logic int_flag;
   logic sec_flag;
   logic next_pri_flag;
   logic next_int_flag;
   logic next_sec_flag;

   // ********************************************************************
   // Status pin synchronisers
   // ********************************************************************
   always_ff @(posedge CLK) begin
      if (RST) begin
         pin_s1 <= 3'h0;
         pin_s2 <= 3'h0;
      end else begin
         pin_s1 <= {PRI_IS_INTERNAL, INT_STABLE, PRI_READY};
         pin_s2 <= pin_s1;
      end
   end

   assign pri_ready_s = pin_s2[0];
   assign int_stable_s = pin_s2[1];
   assign pri_int_s = pin_s2[2];

   // ********************************************************************
   // APB register file
   // ********************************************************************
   assign PREADY = 1'b1;
   assign wr_en = PSEL && PENABLE && PWRITE;
   assign rd_setup = PSEL && !PENABLE && !PWRITE;
   assign mapped = PADDR == OSC_CTRL_OFFSET ||
                   PADDR == SEC_TIMER_CTRL_OFFSET ||
                   PADDR == MODE_STATUS_OFFSET;
   assign PSLVERR = PSEL && PENABLE && !mapped;

   always_comb begin
      next_src_sel = src_sel;
      next_idle_sel = idle_sel;
      next_sleep_sel = sleep_sel;
      next_sec_ctrl = sec_ctrl;
      next_prdata = PRDATA;
      if (wr_en && PADDR == OSC_CTRL_OFFSET) begin
         next_src_sel = PWDATA[SRC_SEL_LSB +: 2];
         next_idle_sel = PWDATA[IDLE_SEL_BIT];
         next_sleep_sel = PWDATA[SLEEP_SEL_BIT];
      end
      if (wr_en && PADDR == SEC_TIMER_CTRL_OFFSET) begin
         next_sec_ctrl = PWDATA[7:0];
      end
      if (rd_setup) begin
         next_prdata = 32'h0;
         if (PADDR == OSC_CTRL_OFFSET) begin
            next_prdata[SRC_SEL_LSB +: 2] = src_sel;
            next_prdata[INT_STABLE_BIT] = int_flag;
            next_prdata[PRIMARY_RUN_MODE_BIT] = pri_flag;
            next_prdata[IDLE_SEL_BIT] = idle_sel;
            next_prdata[SLEEP_SEL_BIT] = sleep_sel;
         end else if (PADDR == SEC_TIMER_CTRL_OFFSET) begin
            next_prdata[7:0] = sec_ctrl;
            next_prdata[SECONDARY_RUN_MODE_BIT] = sec_flag;
         end else if (PADDR == MODE_STATUS_OFFSET) begin
            next_prdata[STATE_LSB +: 3] = state;
            next_prdata[ACTIVE_SRC_LSB +: 2] = active_src;
            next_prdata[PENDING_BIT] = pending_pri;
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         src_sel <= SRC_SEL_RESET;
         idle_sel <= 1'b0;
         sleep_sel <= 1'b0;
         sec_ctrl <= SEC_TIMER_CTRL_RESET;
         PRDATA <= 32'h0;
      end else begin
         src_sel <= next_src_sel;
         idle_sel <= next_idle_sel;
         sleep_sel <= next_sleep_sel;
         sec_ctrl <= next_sec_ctrl;
         PRDATA <= next_prdata;
      end
   end

   // ********************************************************************
   // Power-mode sequencer
   // ********************************************************************
   // select picks the source
   always_comb begin
      if (src_sel == SRC_PRIMARY) begin
         sel_src = SRC_PRIMARY;
      end else if (src_sel == SRC_SECONDARY) begin
         sel_src = SRC_SECONDARY;
      end else begin
         sel_src = SRC_INTERNAL;
      end
   end

   assign auto_go = pending_pri && pri_ready_s &&
                    active_src != SRC_PRIMARY;

   always_comb begin
      next_state = state;
      next_active_src = active_src;
      next_tgt_src = tgt_src;
      next_tgt_idle = tgt_idle;
      next_tgt_sleep = tgt_sleep;
      next_pending_pri = pending_pri;
      next_wdt_reset = 1'b0;
      settle_start = 1'b0;
      unique case (state)
         ST_ACTIVE: begin
            if (SLEEP_EXEC) begin
               next_tgt_src = sel_src;
               next_tgt_idle = idle_sel;
               next_tgt_sleep = sleep_sel && !idle_sel;
               next_pending_pri = 1'b0;
               next_state = ST_STOP;
            end else if (WDT_TIMEOUT) begin
               next_wdt_reset = 1'b1;
            end else if (auto_go) begin
               next_tgt_src = SRC_PRIMARY;
               next_tgt_idle = 1'b0;
               next_tgt_sleep = 1'b0;
               next_pending_pri = 1'b0;
               next_state = ST_STOP;
            end
         end
         ST_STOP: begin
            if (tgt_sleep) begin
               next_state = ST_SLEEP;
            end else if (tgt_src != active_src) begin
               settle_start = 1'b1;
               next_state = ST_SETTLE;
            end else if (tgt_idle) begin
               next_state = ST_IDLE;
            end else begin
               next_state = ST_ACTIVE;
            end
         end
         ST_SETTLE: begin
            if (settle_done) begin
               next_active_src = tgt_src;
               next_state = tgt_idle ? ST_IDLE : ST_ACTIVE;
            end
         end
         ST_IDLE: begin
            if (WAKE_EVENT || WDT_TIMEOUT) begin
               next_tgt_idle = 1'b0;
               next_pending_pri = active_src != SRC_PRIMARY;
               next_state = ST_ACTIVE;
            end
         end
         ST_SLEEP: begin
            if (WAKE_EVENT || WDT_TIMEOUT) begin
               next_tgt_src = active_src;
               next_tgt_idle = 1'b0;
               next_tgt_sleep = 1'b0;
               next_pending_pri = active_src != SRC_PRIMARY;
               settle_start = 1'b1;
               next_state = ST_SETTLE;
            end
         end
         default: begin
            next_state = ST_ACTIVE;
         end
      endcase
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         state <= ST_ACTIVE;
         active_src <= SRC_PRIMARY;
         tgt_src <= SRC_PRIMARY;
         tgt_idle <= 1'b0;
         tgt_sleep <= 1'b0;
         pending_pri <= 1'b0;
         WDT_RESET <= 1'b0;
      end else begin
         state <= next_state;
         active_src <= next_active_src;
         tgt_src <= next_tgt_src;
         tgt_idle <= next_tgt_idle;
         tgt_sleep <= next_tgt_sleep;
         pending_pri <= next_pending_pri;
         WDT_RESET <= next_wdt_reset;
      end
   end

   // Pause counting runs off the sampled source clocks; phase of the
   // new source at the start gives the extra partial period
   source_settle u_settle (
      .clk(CLK),
      .rst(RST),
      .src_clk_pin({INT_OSC_CLK, SEC_OSC_CLK, PRI_OSC_CLK}),
      .sel(next_tgt_src),
      .start(settle_start),
      .done(settle_done)
   );

   assign SYS_CLK_EN = state == ST_ACTIVE || state == ST_IDLE;
   assign CPU_CLK_EN = state == ST_ACTIVE;
   assign ACTIVE_SRC = active_src;

   // ********************************************************************
   // Clock source flags
   // ********************************************************************
   assign complete = state == ST_SETTLE && settle_done;

   always_comb begin
      next_pri_flag = pri_flag;
      next_sec_flag = sec_flag;
      next_int_flag = int_flag;
      if (complete) begin
         next_pri_flag = tgt_src == SRC_PRIMARY;
         next_sec_flag = tgt_src == SRC_SECONDARY;
         next_int_flag = int_stable_s && (tgt_src == SRC_INTERNAL ||
                         (tgt_src == SRC_PRIMARY && pri_int_s));
      end else if (int_stable_s && (active_src == SRC_INTERNAL ||
                   (active_src == SRC_PRIMARY && pri_int_s))) begin
         next_int_flag = 1'b1;
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         pri_flag <= 1'b1;
         int_flag <= 1'b0;
         sec_flag <= 1'b0;
      end else begin
         pri_flag <= next_pri_flag;
         int_flag <= next_int_flag;
         sec_flag <= next_sec_flag;
      end
   end

   // ********************************************************************
   // Assertions
   // ********************************************************************
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);

   sequence s_sleep_taken;
      state == ST_ACTIVE && SLEEP_EXEC;
   endsequence

   sequence s_switch_begins;
      state == ST_STOP && !tgt_sleep && tgt_src != active_src;
   endsequence

   property p_stop_next;
      s_sleep_taken |=> !SYS_CLK_EN && !CPU_CLK_EN;
   endproperty
   a_stop_next: assert property (p_stop_next)
      else $error("clocks not stopped after sleep");

   property p_sample_bits;
      s_sleep_taken |=> tgt_src == $past(sel_src) &&
                        tgt_idle == $past(idle_sel);
   endproperty
   a_sample_bits: assert property (p_sample_bits)
      else $error("mode bits not sampled at sleep");

   property p_no_early_switch;
      state == ST_ACTIVE && !SLEEP_EXEC |=> $stable(active_src);
   endproperty
   a_no_early_switch: assert property (p_no_early_switch)
      else $error("source changed without sleep");

   property p_pause;
      s_switch_begins |=> !SYS_CLK_EN [*8];
   endproperty
   a_pause: assert property (p_pause)
      else $error("clock resumed before settle pause");

   property p_one_flag;
      active_src != SRC_PRIMARY |-> $onehot0({pri_flag, int_flag, sec_flag});
   endproperty
   a_one_flag: assert property (p_one_flag)
      else $error("several source flags set");

   property p_sec_flag;
      complete ##1 active_src == SRC_SECONDARY |-> sec_flag && !pri_flag;
   endproperty
   a_sec_flag: assert property (p_sec_flag)
      else $error("secondary flag wrong after switch");

   property p_idle_cpu;
      state == ST_IDLE |-> SYS_CLK_EN && !CPU_CLK_EN;
   endproperty
   a_idle_cpu: assert property (p_idle_cpu)
      else $error("processor clocked in idle");

   property p_wdt_run;
      state == ST_ACTIVE && WDT_TIMEOUT && !SLEEP_EXEC |=> WDT_RESET;
   endproperty
   a_wdt_run: assert property (p_wdt_run)
      else $error("run watchdog did not reset");

   property p_wdt_idle;
      state == ST_IDLE && WDT_TIMEOUT |=> state == ST_ACTIVE && !WDT_RESET;
   endproperty
   a_wdt_idle: assert property (p_wdt_idle)
      else $error("idle watchdog did not wake");

   property p_wake_keeps;
      state == ST_IDLE && WAKE_EVENT && !wr_en |=>
         $stable(src_sel) && $stable(idle_sel);
   endproperty
   a_wake_keeps: assert property (p_wake_keeps)
      else $error("wake altered mode bits");

   property p_auto_pri;
      state == ST_ACTIVE && auto_go && !SLEEP_EXEC && !WDT_TIMEOUT |=>
         state == ST_STOP && tgt_src == SRC_PRIMARY;
   endproperty
   a_auto_pri: assert property (p_auto_pri)
      else $error("no automatic return to primary");

endmodule : pm_clock_switch

// ==== logic/source_settle.sv ====
`timescale 1ns/1ps
module source_settle
   import pm_clock_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Raw oscillator outputs: primary, secondary, internal
   input wire logic [NUM_SRC-1:0] src_clk_pin,
   // Control
   input wire logic [1:0] sel,
   input wire logic start,
   output logic done
);

   logic [NUM_SRC-1:0] sync1;
   logic [NUM_SRC-1:0] sync2;
   logic [NUM_SRC-1:0] sync3;
   logic [NUM_SRC-1:0] rise;
   logic busy;
   logic [3:0] count;
   logic next_busy;
   logic [3:0] next_count;
   logic next_done;
   logic sel_rise;

   // ********************************************************************
   // Per-source synchroniser and edge detect
   // ********************************************************************
   genvar i;
   generate
      for (i = 0; i < NUM_SRC; i++) begin : g_src
         always_ff @(posedge clk) begin
            if (rst) begin
               sync1[i] <= 1'b0;
               sync2[i] <= 1'b0;
               sync3[i] <= 1'b0;
            end else begin
               sync1[i] <= src_clk_pin[i];
               sync2[i] <= sync1[i];
               sync3[i] <= sync2[i];
            end
         end
         assign rise[i] = sync2[i] & ~sync3[i];
      end
   endgenerate

   always_comb begin
      if (sel == SRC_PRIMARY) begin
         sel_rise = rise[0];
      end else if (sel == SRC_SECONDARY) begin
         sel_rise = rise[1];
      end else begin
         sel_rise = rise[2];
      end
   end

   // ********************************************************************
   // Edge counter
   // ********************************************************************
   always_comb begin
      next_busy = busy;
      next_count = count;
      next_done = 1'b0;
      if (start) begin
         next_busy = 1'b1;
         next_count = 4'h0;
      end else if (busy && sel_rise) begin
         next_count = count + 4'h1;
         // First edge only opens a period; the ninth closes the eighth
         if (count == SETTLE_EDGES) begin
            next_busy = 1'b0;
            next_done = 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         busy <= 1'b0;
         count <= 4'h0;
         done <= 1'b0;
      end else begin
         busy <= next_busy;
         count <= next_count;
         done <= next_done;
      end
   end

   property p_settle_done;
      @(posedge clk) disable iff (rst)
      done |-> count == SETTLE_EDGES + 4'h1 && !busy && $past(busy);
   endproperty
   a_settle_done: assert property (p_settle_done)
      else $error("settle finished before eight source periods");

endmodule : source_settle

// ==== testbench/osc_partner.sv ====
`timescale 1ns/1ps
// ***********************************************************************
// Free-running oscillators facing the clock switch
// ***********************************************************************
module osc_partner #(
   parameter int PRI_HALF = 15,
   parameter int SEC_HALF = 20,
   parameter int INT_HALF = 13,
   parameter int STABLE_NS = 200
) (
   // Oscillator outputs, all slower than half the system clock
   output logic pri_clk,
   output logic sec_clk,
   output logic int_clk,
   // Internal block status
   output logic int_stable
);
   initial begin
      pri_clk = 1'b0;
      forever #(PRI_HALF) pri_clk = ~pri_clk;
   end
   initial begin
      sec_clk = 1'b0;
      forever #(SEC_HALF) sec_clk = ~sec_clk;
   end
   initial begin
      int_clk = 1'b0;
      forever #(INT_HALF) int_clk = ~int_clk;
   end
   initial begin
      int_stable = 1'b0;
      #(STABLE_NS) int_stable = 1'b1;
   end
endmodule : osc_partner

// ==== testbench/power_mode_clock_switch_tb.sv ====
`timescale 1ns/1ps
module power_mode_clock_switch_tb
   import pm_clock_pkg::*;
;
   typedef struct {
      logic [7:0] ctrl;
      logic [1:0] src;
      logic [31:0] osc;
      logic [31:0] sec;
      int minlow;
      int wake;
      logic auto;
   } row_s;
   logic clk, rst, psel, penable, pwrite, pready, pslverr, er;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic sleep_exec, wdt_timeout, wake_event, pri_ready, pri_int;
   logic pri_clk, sec_clk, int_clk, int_stable;
   logic sys_en, cpu_en, wdt_reset;
   logic [1:0] active_src;
   int mismatches, checks_done, low;
   row_s rows [4] = '{
      '{8'h10, 2'h0, 32'h18, 32'h00, 1, 2, 1'b0},
      '{8'h11, 2'h1, 32'h11, 32'h40, 64, 1, 1'b1},
      '{8'h02, 2'h2, 32'h06, 32'h00, 41, 0, 1'b0},
      '{8'h03, 2'h2, 32'h07, 32'h00, 1, 0, 1'b0}
   };
   osc_partner osc (.pri_clk(pri_clk), .sec_clk(sec_clk),
      .int_clk(int_clk), .int_stable(int_stable));
   pm_clock_switch dut (.CLK(clk), .RST(rst), .PSEL(psel),
      .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
      .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .SLEEP_EXEC(sleep_exec),
      .WDT_TIMEOUT(wdt_timeout), .WAKE_EVENT(wake_event),
      .PRI_OSC_CLK(pri_clk), .SEC_OSC_CLK(sec_clk),
      .INT_OSC_CLK(int_clk), .PRI_READY(pri_ready),
      .INT_STABLE(int_stable), .PRI_IS_INTERNAL(pri_int),
      .SYS_CLK_EN(sys_en), .CPU_CLK_EN(cpu_en),
      .ACTIVE_SRC(active_src), .WDT_RESET(wdt_reset));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // ********************************************************************
   // Shared tasks
   // ********************************************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected at %0t: seen %h expected %h",
            $time, seen, exp);
      end
   endtask : check
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : report_and_stop
   task automatic give_up;
      mismatches++;
      report_and_stop();
   endtask : give_up
   // Request held until pready is seen at a rising edge
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge clk);
         if (pready === 1'b1) break;
      end
      if (n == 20) give_up();
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic pulse(input int which);
      @(posedge clk);
      case (which)
         1: wake_event <= 1'b1;
         2: wdt_timeout <= 1'b1;
         default: sleep_exec <= 1'b1;
      endcase
      @(posedge clk);
      wake_event <= 1'b0;
      wdt_timeout <= 1'b0;
      sleep_exec <= 1'b0;
      #1;
   endtask : pulse
   task automatic wait_src(input logic [1:0] v);
      int n;
      for (n = 0; n < 600; n++) begin
         @(posedge clk);
         #1;
         if (active_src === v) break;
      end
      if (n == 600) give_up();
   endtask : wait_src
   // Counts the cycles with the system clock gated
   task automatic do_sleep;
      int n;
      pulse(0);
      check(sys_en, 1'b0); // stop
      for (n = 0; n < 600; n++) begin
         @(posedge clk);
         #1;
         if (sys_en === 1'b1) break;
      end
      if (n == 600) give_up();
      low = n + 1;
   endtask : do_sleep
   // ********************************************************************
   // Main sequence
   // ********************************************************************
   initial begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      sleep_exec = 1'b0;
      wdt_timeout = 1'b0;
      wake_event = 1'b0;
      pri_ready = 1'b0;
      pri_int = 1'b0;
      mismatches = 0;
      checks_done = 0;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      foreach (rows[i]) begin
         apb(1'b1, OSC_CTRL_OFFSET, {24'h0, rows[i].ctrl});
         do_sleep();
         check(low >= rows[i].minlow, 1'b1); // pause
         check(active_src, rows[i].src); // source
         check(cpu_en, !rows[i].ctrl[IDLE_SEL_BIT]); // cpu
         apb(1'b0, OSC_CTRL_OFFSET, 32'h0);
         check(rd, rows[i].osc); // flags
         apb(1'b0, SEC_TIMER_CTRL_OFFSET, 32'h0);
         check(rd, rows[i].sec); // flag
         if (rows[i].wake != 0) begin
            pulse(rows[i].wake);
            check(cpu_en, 1'b1); // woken
            check(wdt_reset, 1'b0); // no reset
            check(active_src, rows[i].src); // run mode
         end
         if (rows[i].auto) begin
            @(posedge clk);
            pri_ready <= 1'b1;
            wait_src(SRC_PRIMARY);
            check(active_src, SRC_PRIMARY); // auto
            apb(1'b0, OSC_CTRL_OFFSET, 32'h0);
            check(rd & 32'h13, {24'h0, rows[i].ctrl} & 32'h13);
            pri_ready <= 1'b0;
         end
         $display("row %0d done", i);
      end
      // Full sleep keeps the source and waits for a wake
      apb(1'b1, OSC_CTRL_OFFSET, 32'h00000020);
      pulse(0);
      repeat (10) @(posedge clk);
      check(sys_en | cpu_en, 1'b0); // full sleep
      check(active_src, SRC_INTERNAL); // source kept
      pulse(1);
      check(sys_en, 1'b0); // settle before resume
      repeat (80) @(posedge clk);
      check(sys_en & cpu_en, 1'b1); // woken
      $display("full sleep done");
      // Reset in mid-run, from an internal-source state
      rst <= 1'b1;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      #1;
      check(active_src, SRC_PRIMARY);
      check(sys_en & cpu_en, 1'b1);
      check(wdt_reset, 1'b0);
      apb(1'b1, OSC_CTRL_OFFSET, 32'h0000000c);
      apb(1'b0, OSC_CTRL_OFFSET, 32'h0);
      check(rd, 32'h00000008); // read-only
      apb(1'b0, MODE_STATUS_OFFSET, 32'h0);
      check(rd, 32'h0);
      apb(1'b0, 8'h0c, 32'h0);
      check(er, 1'b1);
      check(rd, 32'h0);
      pri_int <= 1'b1;
      repeat (4) @(posedge clk);
      apb(1'b0, OSC_CTRL_OFFSET, 32'h0);
      check(rd, 32'h0000000c); // both flags
      $display("reset and registers done");
      apb(1'b1, OSC_CTRL_OFFSET, 32'h00000001);
      repeat (20) @(posedge clk);
      #1;
      check(active_src, SRC_PRIMARY); // no trigger
      pulse(2);
      check(wdt_reset, 1'b1); // run reset
      @(posedge clk);
      #1;
      check(wdt_reset, 1'b0); // one cycle
      $display("select hold and watchdog done");
      report_and_stop();
   end
endmodule : power_mode_clock_switch_tb
